/* design/sbts_params.svh */
// register map, field positions and sizes of the state-based trigger sequencer
`ifndef SBTS_PARAMS_SVH
`define SBTS_PARAMS_SVH
`define SBTS_ADDR_W     8
`define SBTS_DATA_W     32
`define SBTS_TRIG_W     8
`define SBTS_CNT_W      16
`define SBTS_PF_W       15
`define SBTS_NCNT       4
`define SBTS_NFLG       4
`define SBTS_NBR        3
`define SBTS_NENT       12
`define SBTS_ENT_W      4
`define SBTS_SEL_W      2
`define SBTS_ONE_CNT    16'h0001
`define SBTS_ONE_PF     15'h0001
// register word addresses
`define SBTS_OFF_CTRL   8'h00
`define SBTS_OFF_STAT   8'h01
`define SBTS_OFF_FINIT  8'h02
`define SBTS_OFF_DEFPF  8'h03
`define SBTS_OFF_CINIT  8'h04
`define SBTS_OFF_CNT    8'h08
`define SBTS_OFF_FLAGS  8'h0C
`define SBTS_OFF_ENT    8'h20
`define SBTS_OFF_ENTEND 8'h38
// control register bits
`define SBTS_CTRL_ARM   0
`define SBTS_CTRL_STOP  1
`define SBTS_CTRL_SQ    2
`define SBTS_CTRL_SEG   3
// branch word A fields
`define SBTS_A_MASK     7:0
`define SBTS_A_INV      8
`define SBTS_A_USECMP   9
`define SBTS_A_ONFLAG   10
`define SBTS_A_RES      12:11
`define SBTS_A_CMPOP    15:13
`define SBTS_A_LOR      16
`define SBTS_A_VALID    17
`define SBTS_A_COP      19:18
`define SBTS_A_CSEL     21:20
`define SBTS_A_FOP      23:22
`define SBTS_A_FSEL     25:24
`define SBTS_A_BACT     28:26
`define SBTS_A_GOTO     29
`define SBTS_A_DEST     31:30
// branch word B fields
`define SBTS_B_CONST    15:0
`define SBTS_B_PF       30:16
`define SBTS_B_HASPF    31
`endif

/* design/sbts_pkg.sv */
// types of the state-based trigger sequencer
`default_nettype none
package sbts_pkg;
	typedef enum logic [1:0] {
		SBTS_IDLE = 2'b00,
		SBTS_RUN  = 2'b01,
		SBTS_POST = 2'b10,
		SBTS_DONE = 2'b11
	} sbts_phase_t;
	typedef enum logic [1:0] {
		SBTS_C_NONE = 2'b00,
		SBTS_C_INC  = 2'b01,
		SBTS_C_DEC  = 2'b10,
		SBTS_C_RLD  = 2'b11
	} sbts_cop_t;
	typedef enum logic [2:0] {
		SBTS_B_NONE  = 3'b000,
		SBTS_B_TRIG  = 3'b001,
		SBTS_B_SEG   = 3'b010,
		SBTS_B_START = 3'b011,
		SBTS_B_STOP  = 3'b100
	} sbts_bact_t;
	typedef enum logic [2:0] {
		SBTS_GT = 3'b000,
		SBTS_GE = 3'b001,
		SBTS_EQ = 3'b010,
		SBTS_NE = 3'b011,
		SBTS_LE = 3'b100,
		SBTS_LT = 3'b101
	} sbts_cmp_t;
endpackage
`default_nettype wire

/* design/sbts_sequencer.sv */
// state-based trigger sequencer: branch evaluation, resources and buffer write gate
`timescale 1ns/10ps
`default_nettype none
`include "sbts_params.svh"

module sbts_sequencer (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic [`SBTS_ADDR_W-1:0]   reg_addr,
	input  wire logic [`SBTS_DATA_W-1:0]   reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [`SBTS_DATA_W-1:0]   reg_rdata,
	input  wire logic [`SBTS_TRIG_W-1:0]   trig_cond,
	output logic                           buf_we,
	output logic                           seg_next,
	output logic                           seg_discard,
	output logic      [`SBTS_SEL_W-1:0]    seg_idx,
	output logic                           acq_done,
	output logic                           acq_triggered
);
	// configuration and resources
	logic [`SBTS_DATA_W-1:0] cfg_a_q [`SBTS_NENT];
	logic [`SBTS_DATA_W-1:0] cfg_b_q [`SBTS_NENT];
	logic [`SBTS_CNT_W-1:0]  cinit_q [`SBTS_NCNT];
	logic [`SBTS_CNT_W-1:0]  cnt_q   [`SBTS_NCNT];
	logic [`SBTS_NFLG-1:0]   finit_q;
	logic [`SBTS_NFLG-1:0]   flag_q;
	logic [`SBTS_PF_W-1:0]   defpf_q;
	logic                    sq_mode_q;
	logic                    seg_mode_q;
	// acquisition state
	sbts_pkg::sbts_phase_t   phase_q;
	logic [`SBTS_SEL_W-1:0]  state_q;
	logic                    store_q;
	logic                    forced_q;
	logic [`SBTS_PF_W-1:0]   pf_left_q;
	logic                    seg_busy_q;
	logic [`SBTS_PF_W-1:0]   seg_left_q;
	logic [`SBTS_SEL_W-1:0]  seg_idx_q;
	logic                    seg_next_q;
	logic                    seg_disc_q;
	logic                    trig_q;
	logic [`SBTS_DATA_W-1:0] rdata_q;
	// decoded controls
	logic                    arm;
	logic                    stop_req;
	logic                    active;
	logic [`SBTS_NBR-1:0]    hit;
	logic                    sel_ok;
	logic [`SBTS_DATA_W-1:0] sel_a;
	logic [`SBTS_DATA_W-1:0] sel_b;
	sbts_pkg::sbts_bact_t    bact;
	logic [`SBTS_PF_W-1:0]   pf_eff;
	logic                    ent_hit;
	logic [`SBTS_ENT_W-1:0]  ent_idx;

	// control strobes decoded straight off the write, so they last only that cycle
	assign arm      = reg_wr && reg_addr == `SBTS_OFF_CTRL && reg_wdata[`SBTS_CTRL_ARM];
	assign stop_req = reg_wr && reg_addr == `SBTS_OFF_CTRL && reg_wdata[`SBTS_CTRL_STOP];
	assign active   = phase_q == sbts_pkg::SBTS_RUN || phase_q == sbts_pkg::SBTS_POST;
	assign ent_hit  = reg_addr >= `SBTS_OFF_ENT && reg_addr < `SBTS_OFF_ENTEND;
	assign ent_idx  = ent_hit ? (`SBTS_ENT_W)'((reg_addr - `SBTS_OFF_ENT) >> 1) : '0;

	// mode bits follow every control write, so they land on the same edge as an arm
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sq_mode_q  <= 1'b0;
			seg_mode_q <= 1'b0;
		end else if (reg_wr && reg_addr == `SBTS_OFF_CTRL) begin
			sq_mode_q  <= reg_wdata[`SBTS_CTRL_SQ];
			seg_mode_q <= reg_wdata[`SBTS_CTRL_SEG];
		end
	end

	// flag initial values, copied into the flags on every arm
	always_ff @(posedge clk_sys) begin
		if (rst)
			finit_q <= '0;
		else if (reg_wr && reg_addr == `SBTS_OFF_FINIT)
			finit_q <= reg_wdata[`SBTS_NFLG-1:0];
	end

	// default post-fill stands in for the trigger-position ratio
	always_ff @(posedge clk_sys) begin
		if (rst)
			defpf_q <= '0;
		else if (reg_wr && reg_addr == `SBTS_OFF_DEFPF)
			defpf_q <= reg_wdata[`SBTS_PF_W-1:0];
	end

	// branch table, two words per branch, writable any time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < `SBTS_NENT; i++) begin
				cfg_a_q[i] <= '0;
				cfg_b_q[i] <= '0;
			end
		end else if (reg_wr && ent_hit) begin
			if (reg_addr[0])
				cfg_b_q[ent_idx] <= reg_wdata;
			else
				cfg_a_q[ent_idx] <= reg_wdata;
		end
	end

	// per-branch condition of the current state: trigger term combined with one compare
	genvar gb;
	generate
		for (gb = 0; gb < `SBTS_NBR; gb++) begin : g_br
			logic [`SBTS_ENT_W-1:0] e;
			logic [`SBTS_DATA_W-1:0] wa;
			logic [`SBTS_CNT_W-1:0] lhs;
			logic [`SBTS_CNT_W-1:0] rhs;
			logic                   tt;
			logic                   cc;
			assign e   = (`SBTS_ENT_W)'(state_q * `SBTS_NBR + gb);
			assign wa  = cfg_a_q[e];
			// the right operand is always the stored constant, never a resource
			assign rhs = cfg_b_q[e][`SBTS_B_CONST];
			assign lhs = wa[`SBTS_A_ONFLAG] ?
				{{(`SBTS_CNT_W-1){1'b0}}, flag_q[wa[`SBTS_A_RES]]} :
				cnt_q[wa[`SBTS_A_RES]];
			// trigger term: every masked input high, then the optional inversion
			assign tt  = ((trig_cond & wa[`SBTS_A_MASK]) == wa[`SBTS_A_MASK]) ^ wa[`SBTS_A_INV];
			always_comb begin
				unique case (sbts_pkg::sbts_cmp_t'(wa[`SBTS_A_CMPOP]))
					sbts_pkg::SBTS_GT: cc = lhs >  rhs;
					sbts_pkg::SBTS_GE: cc = lhs >= rhs;
					sbts_pkg::SBTS_EQ: cc = lhs == rhs;
					sbts_pkg::SBTS_NE: cc = lhs != rhs;
					sbts_pkg::SBTS_LE: cc = lhs <= rhs;
					sbts_pkg::SBTS_LT: cc = lhs <  rhs;
					default:           cc = 1'b0;
				endcase
			end
			assign hit[gb] = wa[`SBTS_A_VALID] && (!wa[`SBTS_A_USECMP] ? tt :
				(wa[`SBTS_A_LOR] ? (tt || cc) : (tt && cc)));
		end
	endgenerate

	// priority pick: earliest true branch supplies every action of this cycle
	always_comb begin
		sel_ok = 1'b0;
		sel_a  = '0;
		sel_b  = '0;
		for (int b = `SBTS_NBR - 1; b >= 0; b--) begin
			if (hit[b] && active) begin
				sel_ok = 1'b1;
				sel_a  = cfg_a_q[(`SBTS_ENT_W)'(state_q * `SBTS_NBR + b)];
				sel_b  = cfg_b_q[(`SBTS_ENT_W)'(state_q * `SBTS_NBR + b)];
			end
		end
	end

	assign bact   = sel_ok ? sbts_pkg::sbts_bact_t'(sel_a[`SBTS_A_BACT]) : sbts_pkg::SBTS_B_NONE;
	assign pf_eff = sel_b[`SBTS_B_HASPF] ? sel_b[`SBTS_B_PF] : defpf_q;

	// counters: one per generate entry, the one the branch selects updated in the same cycle as other actions
	genvar gc;
	generate
		for (gc = 0; gc < `SBTS_NCNT; gc++) begin : g_cnt
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					cinit_q[gc] <= '0;
				end else if (reg_wr && reg_addr == `SBTS_OFF_CINIT + gc) begin
					cinit_q[gc] <= reg_wdata[`SBTS_CNT_W-1:0];
				end
			end
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					cnt_q[gc] <= '0;
				end else if (arm) begin
					cnt_q[gc] <= cinit_q[gc];
				end else if (sel_ok && sel_a[`SBTS_A_CSEL] == gc) begin
					unique case (sbts_pkg::sbts_cop_t'(sel_a[`SBTS_A_COP]))
						sbts_pkg::SBTS_C_NONE: cnt_q[gc] <= cnt_q[gc];
						sbts_pkg::SBTS_C_INC:  cnt_q[gc] <= cnt_q[gc] + `SBTS_ONE_CNT;
						sbts_pkg::SBTS_C_DEC:  cnt_q[gc] <= cnt_q[gc] - `SBTS_ONE_CNT;
						sbts_pkg::SBTS_C_RLD:  cnt_q[gc] <= cinit_q[gc];
					endcase
				end
			end
		end
	endgenerate

	// status flags; code 3 of the flag action field does nothing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_q <= '0;
		end else if (arm) begin
			flag_q <= finit_q;
		end else if (sel_ok) begin
			if (sel_a[`SBTS_A_FOP] == 2'h1)
				flag_q[sel_a[`SBTS_A_FSEL]] <= 1'b1;
			else if (sel_a[`SBTS_A_FOP] == 2'h2)
				flag_q[sel_a[`SBTS_A_FSEL]] <= 1'b0;
		end
	end

	// sequencer state: goto takes effect for the next evaluation
	always_ff @(posedge clk_sys) begin
		if (rst || arm)
			state_q <= '0;
		else if (sel_ok && sel_a[`SBTS_A_GOTO])
			state_q <= sel_a[`SBTS_A_DEST];
	end

	// storage gate: closed at arm in qualified mode, so nothing lands before a start;
	// the mode is taken from the arming write, as the mode flop only follows on that edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			store_q <= 1'b0;
		end else if (arm) begin
			store_q <= !reg_wdata[`SBTS_CTRL_SQ];
		end else if (sq_mode_q && !seg_mode_q) begin
			if (bact == sbts_pkg::SBTS_B_START)
				store_q <= 1'b1;
			else if (bact == sbts_pkg::SBTS_B_STOP)
				store_q <= 1'b0;
		end
	end

	// write gate is a combination of flops so the buffer sees the current sample
	assign buf_we = active && store_q;

	// run phase: a paused post-fill just waits on the gate, only the host can cut it short
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_q <= sbts_pkg::SBTS_IDLE;
		end else if (arm) begin
			phase_q <= sbts_pkg::SBTS_RUN;
		end else if (stop_req && active) begin
			phase_q <= sbts_pkg::SBTS_DONE;
		end else if (phase_q == sbts_pkg::SBTS_RUN && bact == sbts_pkg::SBTS_B_TRIG) begin
			// zero post-fill ends the run on the trigger sample itself
			phase_q <= pf_eff == '0 ? sbts_pkg::SBTS_DONE : sbts_pkg::SBTS_POST;
		end else if (phase_q == sbts_pkg::SBTS_POST && buf_we && pf_left_q == `SBTS_ONE_PF) begin
			phase_q <= sbts_pkg::SBTS_DONE;
		end
	end

	// post-fill countdown moves only on stored samples, so a closed gate pauses it
	always_ff @(posedge clk_sys) begin
		if (rst || arm) begin
			pf_left_q <= '0;
		end else if (phase_q == sbts_pkg::SBTS_RUN && bact == sbts_pkg::SBTS_B_TRIG) begin
			pf_left_q <= pf_eff;
		end else if (phase_q == sbts_pkg::SBTS_POST && buf_we) begin
			pf_left_q <= pf_left_q - `SBTS_ONE_PF;
		end
	end

	// triggered level: the final trigger or a host stop, held until the next arm
	always_ff @(posedge clk_sys) begin
		if (rst || arm)
			trig_q <= 1'b0;
		else if (stop_req && active)
			trig_q <= 1'b1;
		else if (phase_q == sbts_pkg::SBTS_RUN && bact == sbts_pkg::SBTS_B_TRIG)
			trig_q <= 1'b1;
	end

	// forced stop marks a run that the host ended rather than the flow
	always_ff @(posedge clk_sys) begin
		if (rst || arm)
			forced_q <= 1'b0;
		else if (stop_req && active)
			forced_q <= 1'b1;
	end

	// segments: a retrigger while a segment fills cuts it short and flags the loss
	always_ff @(posedge clk_sys) begin
		if (rst || arm) begin
			seg_busy_q <= 1'b0;
			seg_left_q <= '0;
			seg_idx_q  <= '0;
			seg_next_q <= 1'b0;
			seg_disc_q <= 1'b0;
		end else begin
			seg_next_q <= 1'b0;
			seg_disc_q <= 1'b0;
			if (seg_mode_q && phase_q == sbts_pkg::SBTS_RUN &&
				(bact == sbts_pkg::SBTS_B_SEG || bact == sbts_pkg::SBTS_B_TRIG)) begin
				if (seg_busy_q) begin
					seg_disc_q <= 1'b1;
					seg_next_q <= 1'b1;
					seg_idx_q  <= seg_idx_q + 1'b1;
				end
				if (bact == sbts_pkg::SBTS_B_SEG) begin
					seg_busy_q <= pf_eff != '0;
					seg_left_q <= pf_eff;
					if (pf_eff == '0 && !seg_busy_q) begin
						seg_next_q <= 1'b1;
						seg_idx_q  <= seg_idx_q + 1'b1;
					end
				end else begin
					seg_busy_q <= 1'b0;
				end
			end else if (seg_busy_q && buf_we) begin
				// a segment closes once its own post-fill samples are stored
				seg_left_q <= seg_left_q - `SBTS_ONE_PF;
				if (seg_left_q == `SBTS_ONE_PF) begin
					seg_busy_q <= 1'b0;
					seg_next_q <= 1'b1;
					seg_idx_q  <= seg_idx_q + 1'b1;
				end
			end
		end
	end

	// buffer-side outputs straight from their flops, except acq_done, which is decoded from phase_q
	assign seg_next      = seg_next_q;
	assign seg_discard   = seg_disc_q;
	assign seg_idx       = seg_idx_q;
	assign acq_done      = phase_q == sbts_pkg::SBTS_DONE;
	assign acq_triggered = trig_q;

	// read data stands one cycle after the strobe and only then
	always_ff @(posedge clk_sys) begin
		if (rst || !reg_rd) begin
			rdata_q <= '0;
		end else if (ent_hit) begin
			rdata_q <= reg_addr[0] ? cfg_b_q[ent_idx] : cfg_a_q[ent_idx];
		end else if (reg_addr >= `SBTS_OFF_CINIT && reg_addr < `SBTS_OFF_CNT) begin
			rdata_q <= {16'h0000, cinit_q[reg_addr[`SBTS_SEL_W-1:0]]};
		end else if (reg_addr >= `SBTS_OFF_CNT && reg_addr < `SBTS_OFF_FLAGS) begin
			rdata_q <= {16'h0000, cnt_q[reg_addr[`SBTS_SEL_W-1:0]]};
		end else begin
			unique case (reg_addr)
				`SBTS_OFF_CTRL:  rdata_q <= {28'h0000000, seg_mode_q, sq_mode_q, 2'h0};
				`SBTS_OFF_STAT:  rdata_q <= {23'h000000, seg_idx_q, state_q, forced_q,
					trig_q, store_q, phase_q};
				`SBTS_OFF_FINIT: rdata_q <= {28'h0000000, finit_q};
				`SBTS_OFF_DEFPF: rdata_q <= {17'h00000, defpf_q};
				`SBTS_OFF_FLAGS: rdata_q <= {28'h0000000, flag_q};
				default:         rdata_q <= '0;
			endcase
		end
	end

	// read data leaves from its flop, zero outside the answer cycle
	assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

/* testbench/sbts_monitor.sv */
// port-level checks of the trigger sequencer, bound to every instance
`timescale 1ns/10ps
`default_nettype none
`include "sbts_params.svh"
module sbts_monitor (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic [`SBTS_ADDR_W-1:0] reg_addr,
	input wire logic [`SBTS_DATA_W-1:0] reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [`SBTS_DATA_W-1:0] reg_rdata,
	input wire logic [`SBTS_TRIG_W-1:0] trig_cond,
	input wire logic                    buf_we,
	input wire logic                    seg_next,
	input wire logic                    seg_discard,
	input wire logic [`SBTS_SEL_W-1:0]  seg_idx,
	input wire logic                    acq_done,
	input wire logic                    acq_triggered
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// host writes that start or cut a run
	sequence s_arm;
		reg_wr && reg_addr == `SBTS_OFF_CTRL && reg_wdata[`SBTS_CTRL_ARM] && !reg_wdata[`SBTS_CTRL_STOP];
	endsequence
	sequence s_stop;
		reg_wr && reg_addr == `SBTS_OFF_CTRL && reg_wdata[`SBTS_CTRL_STOP] && !reg_wdata[`SBTS_CTRL_ARM];
	endsequence
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (reg_rd && reg_addr[7:4] == 4'h1 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_mirror: assert property (reg_rd && reg_addr == `SBTS_OFF_STAT |=>
		reg_rdata[8:7] == $past(seg_idx) && reg_rdata[3] == $past(acq_triggered)
		&& (reg_rdata[1:0] == 2'h3) == $past(acq_done)) else $error("status word wrong");
	a_arm_gate: assert property (s_arm |=> buf_we == !$past(reg_wdata[`SBTS_CTRL_SQ])
		&& !acq_done && !acq_triggered) else $error("arm left wrong gate or flags");
	a_done_gate_off: assert property (acq_done |-> !buf_we)
		else $error("storing after run end");
	a_done_sticky: assert property (acq_done && !reg_wr |=> acq_done)
		else $error("done dropped");
	a_trig_sticky: assert property (acq_triggered && !reg_wr |=> acq_triggered)
		else $error("triggered dropped");
	a_manual_stop: assert property (s_stop ##0 (acq_triggered && !acq_done) |=> acq_done)
		else $error("manual stop did not end run");
	a_discard_pairs: assert property (seg_discard |-> seg_next)
		else $error("discard without segment switch");
	a_seg_step: assert property (!$past(reg_wr) && seg_idx != $past(seg_idx) |->
		seg_idx == $past(seg_idx) + 2'h1) else $error("segment index skipped");
endmodule
bind sbts_sequencer sbts_monitor mon (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.trig_cond(trig_cond), .buf_we(buf_we), .seg_next(seg_next), .seg_discard(seg_discard),
	.seg_idx(seg_idx), .acq_done(acq_done), .acq_triggered(acq_triggered));
`default_nettype wire

/* testbench/sbts_probe_src.sv */
// stand-in for the observed user logic: replays requested condition levels
`timescale 1ns/10ps
`default_nettype none
`include "sbts_params.svh"
module sbts_probe_src (
	input  wire logic [`SBTS_TRIG_W-1:0] cond_req,
	input  wire logic                    clk_sys,
	output logic      [`SBTS_TRIG_W-1:0] trig_cond
);
	// registered like a sampled net, so levels only move just after an edge
	always @(posedge clk_sys) begin
		trig_cond <= cond_req;
	end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the trigger sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sbts_params.svh"
module tb;
	localparam logic [1:0] c_inc = sbts_pkg::SBTS_C_INC;
	localparam logic [1:0] c_dec = sbts_pkg::SBTS_C_DEC;
	localparam logic [1:0] c_rld = sbts_pkg::SBTS_C_RLD;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  cond_req = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, d;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  trig_cond;
	logic        buf_we, seg_next, seg_discard, acq_done, acq_triggered;
	logic [1:0]  seg_idx;
	int          err_total = 0;
	int          checks = 0;
	int          cycles = 0;
	sbts_probe_src src (.cond_req(cond_req), .clk_sys(clk_sys), .trig_cond(trig_cond));
	sbts_sequencer dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_cond(trig_cond),
		.buf_we(buf_we), .seg_next(seg_next), .seg_discard(seg_discard), .seg_idx(seg_idx),
		.acq_done(acq_done), .acq_triggered(acq_triggered));
	// 100 ns clock
	initial forever #50 clk_sys = ~clk_sys;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// strobe lowered then one idle edge, so back-to-back calls never clash
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk_sys);
	endtask
	task automatic pulse(input logic [7:0] v, input int n);
		cond_req <= v;
		repeat (n) @(posedge clk_sys);
		cond_req <= 8'h00;
		@(posedge clk_sys);
	endtask
	task automatic gate(input logic e);
		@(posedge clk_sys);
		chk("write gate", {31'h0, buf_we}, {31'h0, e});
	endtask
	// branch word A; resource index fixed to 1, go = {enable, dest}
	function automatic logic [31:0] fa(input logic [7:0] m, input logic [2:0] op, input logic uc,
		input logic [1:0] cop, cs, fop, fs, input logic [2:0] ba, go);
		return {go[1:0], go[2], ba, fs, fop, cs, cop, 1'b1, 1'b0, op, 2'h1, 1'b0, uc, 1'b0, m};
	endfunction
	task automatic br(input int e, input logic [31:0] a, b);
		wr(`SBTS_OFF_ENT + 8'(2 * e), a);
		wr(`SBTS_OFF_ENT + 8'(2 * e + 1), b);
	endtask
	// post-fill samples stored until the run ends
	task automatic post_count(output int n);
		n = 0;
		repeat (60) begin
			@(posedge clk_sys);
			if (acq_done === 1'b1) break;
			if (buf_we === 1'b1 && acq_triggered === 1'b1) n++;
		end
	endtask
	task automatic t_res;
		wr(`SBTS_OFF_CINIT, 32'h5);
		wr(`SBTS_OFF_CINIT + 8'h01, 32'h9);
		wr(`SBTS_OFF_FINIT, 32'h1);
		br(0, fa(8'h01, 3'h0, 1'b0, c_inc, 2'h0, 2'h1, 2'h1, 3'h0, 3'h5), 32'h0);
		br(1, fa(8'h03, 3'h0, 1'b0, c_dec, 2'h0, 2'h0, 2'h0, 3'h0, 3'h0), 32'h0);
		br(3, fa(8'h02, 3'h0, 1'b0, c_rld, 2'h0, 2'h2, 2'h0, 3'h0, 3'h6), 32'h0);
		br(6, fa(8'h10, 3'h0, 1'b0, c_dec, 2'h1, 2'h0, 2'h0, 3'h0, 3'h0), 32'h0);
		wr(`SBTS_OFF_CTRL, 32'h1);
		rd(`SBTS_OFF_CNT);
		chk("counter init", d, 32'h5);
		rd(`SBTS_OFF_FLAGS);
		chk("flag init", d, 32'h1);
		pulse(8'h03, 1);
		rd(`SBTS_OFF_CNT);
		chk("increment", d, 32'h6);
		rd(`SBTS_OFF_FLAGS);
		chk("flag set", d, 32'h3);
		rd(`SBTS_OFF_STAT);
		chk("state", {30'h0, d[6:5]}, 32'h1);
		pulse(8'h02, 1);
		rd(`SBTS_OFF_CNT);
		chk("reload", d, 32'h5);
		rd(`SBTS_OFF_FLAGS);
		chk("flag clear", d, 32'h2);
		pulse(8'h10, 1);
		rd(`SBTS_OFF_CNT + 8'h01);
		chk("decrement", d, 32'h8);
		$display("test resources done");
	endtask
	task automatic t_cmp;
		logic e;
		for (int op = 0; op < 6; op++) begin
			for (int k = 8; k < 10; k++) begin
				case (op)
					0: e = 9 > k;
					1: e = 9 >= k;
					2: e = 9 == k;
					3: e = 9 != k;
					4: e = 9 <= k;
					default: e = 9 < k;
				endcase
				br(0, fa(8'h00, 3'(op), 1'b1, c_inc, 2'h2, 2'h0, 2'h0, 3'h0, 3'h5), 32'(k));
				wr(`SBTS_OFF_CTRL, 32'h1);
				repeat (3) @(posedge clk_sys);
				rd(`SBTS_OFF_CNT + 8'h02);
				chk("compare", d, {31'h0, e});
			end
		end
		$display("test compare done");
	endtask
	task automatic t_trig;
		int n;
		wr(`SBTS_OFF_DEFPF, 32'h4);
		for (int i = 0; i < 2; i++) begin
			br(0, fa(8'h04, 3'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h1, 3'h0), {1'(i == 0), 31'h30000});
			wr(`SBTS_OFF_CTRL, 32'h1);
			pulse(8'h04, 1);
			post_count(n);
			chk("post-fill count", 32'(n), i == 0 ? 32'h3 : 32'h4);
			rd(`SBTS_OFF_STAT);
			chk("run done", {30'h0, d[1:0]}, 32'h3);
		end
		$display("test trigger done");
	endtask
	task automatic t_qual;
		int n;
		br(0, fa(8'h01, 3'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h3, 3'h0), 32'h0);
		br(1, fa(8'h02, 3'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h1, 3'h0), 32'h80050000);
		br(2, fa(8'h08, 3'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h4, 3'h0), 32'h0);
		wr(`SBTS_OFF_CTRL, 32'h5);
		gate(1'b0);
		pulse(8'h01, 1);
		gate(1'b1);
		pulse(8'h02, 1);
		pulse(8'h08, 1);
		gate(1'b0);
		repeat (20) @(posedge clk_sys);
		chk("paused", {31'h0, acq_done}, 32'h0);
		pulse(8'h01, 1);
		post_count(n);
		chk("rest of post-fill", 32'(n), 32'h3);
		wr(`SBTS_OFF_CTRL, 32'h5);
		pulse(8'h01, 1);
		pulse(8'h02, 1);
		pulse(8'h08, 1);
		wr(`SBTS_OFF_CTRL, 32'h6);
		rd(`SBTS_OFF_STAT);
		chk("forced stop", {28'h0, d[4:3], d[1:0]}, 32'hF);
		chk("triggered pin", {31'h0, acq_triggered}, 32'h1);
		wr(`SBTS_OFF_CTRL, 32'h1);
		pulse(8'h08, 1);
		gate(1'b1);
		$display("test storage done");
	endtask
	task automatic t_seg;
		logic [1:0] i0;
		int         nx;
		int         ds;
		br(0, fa(8'h01, 3'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h2, 3'h0), 32'h80020000);
		wr(`SBTS_OFF_CTRL, 32'h9);
		i0 = 2'h0;
		chk("segment index at arm", {30'h0, seg_idx}, 32'h0);
		for (int i = 1; i < 6; i++) begin
			pulse(8'h01, 1);
			repeat (4) @(posedge clk_sys);
			chk("segment index", {30'h0, seg_idx}, {30'h0, i0 + 2'(i)});
		end
		nx = 0;
		ds = 0;
		fork
			pulse(8'h01, 2);
			repeat (8) begin
				@(posedge clk_sys);
				nx += seg_next;
				ds += seg_discard;
			end
		join
		chk("segment switches", 32'(nx), 32'h2);
		chk("segment discards", 32'(ds), 32'h1);
		chk("index after cut", {30'h0, seg_idx}, {30'h0, i0 + 2'h3});
		$display("test segments done");
	endtask
	// main sequence: reset, register bus sanity, then each scenario
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(`SBTS_OFF_STAT);
		chk("status reset", d, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10);
		chk("unmapped", d, 32'h0);
		t_res();
		t_cmp();
		t_trig();
		t_qual();
		t_seg();
		conclude();
	end
endmodule
`default_nettype wire
